// >>> rtl/adcps_defs.svh
// register map, field positions, reset values and timing counts
//
// Function
// - calibrate after power-down exit, never after sleep
// - power states never alter configuration registers
// - power-up delay of 8.4e6 cycles before calibration
// - primary calibration lasts 1.0e6 cycles
// - calibration complete flag in link status register
// - host waits for primary calibration first
// - host first writes power-down to power mode
// - host doubles divider unless already eight
// - host writes three tuning registers fixed values
// - host rewrites power mode back to normal
// - host polls calibration flag until set
// - host restores divider unless eight desired
// - device enters link initialization after calibration
// - exit delay 262e3 cycles, then 1e6 calibration
// - host always uses full sequence around power-down
// - two's complement default, offset binary selectable
// - subclass 1 or 0, never subclass 2
// - one or two lanes, multiframe, scrambling
// - link test sequences, no RPAT or JSPAT
// - no idle mode, transport patterns, polarity inversion
// - divider selects 1, 2, 4 or 8
// - divider change restarts link initialization
`ifndef ADCPS_DEFS_SVH
`define ADCPS_DEFS_SVH

`define ADCPS_REG_PWR      8'h02
`define ADCPS_REG_DIV      8'h13
`define ADCPS_REG_TUNA     8'h16
`define ADCPS_REG_TUNB     8'h1e
`define ADCPS_REG_TUNC     8'h28
`define ADCPS_REG_CFG      8'h60
`define ADCPS_REG_KCFG     8'h61
`define ADCPS_REG_LINK     8'h6c

`define ADCPS_ST_CALDONE   0
`define ADCPS_ST_LINKUP    1
`define ADCPS_ST_CALBUSY   2

`define ADCPS_CFG_OFFBIN   0
`define ADCPS_CFG_TWOLANE  1
`define ADCPS_CFG_SCRAM    2
`define ADCPS_CFG_SUB1     3

`define ADCPS_PWR_NORMAL   8'h00
`define ADCPS_PWR_DOWN     8'h01
`define ADCPS_PWR_SLEEP    8'h02
`define ADCPS_DIV_RESET    8'h00
`define ADCPS_DIV_BY8      2'h3
`define ADCPS_CFG_RESET    8'h08
`define ADCPS_K_RESET      8'h14
`define ADCPS_K_MIN1       8'h09
`define ADCPS_K_MIN2       8'h11
`define ADCPS_K_MAX        8'h20

// arbitrary tuning values
`define ADCPS_TUNA_VAL     8'h5a
`define ADCPS_TUNB_VAL     8'h3c
`define ADCPS_TUNC_VAL     8'ha5

// times are in sampling clock cycles; one clock per sample
`define ADCPS_CYC_PER_SMP  1
`define ADCPS_PUP_SMP      8400000
`define ADCPS_CALP_SMP     1000000
`define ADCPS_PDX_SMP      262000
`define ADCPS_CAL_SMP      1000000
`define ADCPS_LINK_SMP     16
`define ADCPS_PUP_CYC      (`ADCPS_PUP_SMP * `ADCPS_CYC_PER_SMP)
`define ADCPS_CALP_CYC     (`ADCPS_CALP_SMP * `ADCPS_CYC_PER_SMP)
`define ADCPS_PDX_CYC      (`ADCPS_PDX_SMP * `ADCPS_CYC_PER_SMP)
`define ADCPS_CAL_CYC      (`ADCPS_CAL_SMP * `ADCPS_CYC_PER_SMP)
`define ADCPS_LINK_CYC     (`ADCPS_LINK_SMP * `ADCPS_CYC_PER_SMP)

`define ADCPS_AXI_CTRL     4'h0
`define ADCPS_AXI_STATUS   4'h4
`define ADCPS_RESP_OKAY    2'h0
`define ADCPS_RESP_SLVERR  2'h2

`endif

// >>> rtl/adcps_pkg.sv
// types shared by both ends of the calibration sequencer
package adcps_pkg;

  typedef enum logic [3:0] {
    DEV_WAIT  = 4'h0,
    DEV_PUP   = 4'h1,
    DEV_CALP  = 4'h2,
    DEV_LINK  = 4'h3,
    DEV_RUN   = 4'h4,
    DEV_PD    = 4'h5,
    DEV_PDX   = 4'h6,
    DEV_CAL   = 4'h7,
    DEV_SLEEP = 4'h8
  } adcps_dev_state_t;

  typedef enum logic [3:0] {
    HST_IDLE  = 4'h0,
    HST_POLLP = 4'h1,
    HST_PD    = 4'h2,
    HST_DIV   = 4'h3,
    HST_TUNA  = 4'h4,
    HST_TUNB  = 4'h5,
    HST_TUNC  = 4'h6,
    HST_NORM  = 4'h7,
    HST_POLLC = 4'h8,
    HST_REST  = 4'h9
  } adcps_hst_state_t;

  typedef enum logic [2:0] {
    TP_NONE   = 3'h0,
    TP_D215   = 3'h1,
    TP_K285   = 3'h2,
    TP_ILA    = 3'h3,
    TP_PRBS7  = 3'h4,
    TP_PRBS23 = 3'h5,
    TP_RAMP   = 3'h6
  } adcps_test_t;

endpackage

// >>> rtl/adcps_if.sv
// configuration port between host controller and converter
`timescale 1ns/1ps
interface adcps_if;
  logic       wrEn;
  logic       rdEn;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rdValid;

  modport dev  (input wrEn, rdEn, addr, wdata, output rdata, rdValid);
  modport host (output wrEn, rdEn, addr, wdata, input rdata, rdValid);
endinterface

// >>> rtl/adcps_host_end.sv
// host controller running the secondary calibration sequence
`timescale 1ns/1ps
`include "adcps_defs.svh"
module adcps_host_end
  import adcps_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  adcps_if.host            dev,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  adcps_hst_state_t st_q;
  logic [3:0]  awA_q, arA;
  logic [7:0]  wD_q;
  logic        wS_q, awGot_q, wGot_q, doWr, start;
  logic        busy_q, done_q, rdPend_q;
  logic        wrEn_q, rdEn_q;
  logic [7:0]  addr_q, wdat_q;
  logic [1:0]  want_q, dbl;

  assign dev.wrEn  = wrEn_q;
  assign dev.rdEn  = rdEn_q;
  assign dev.addr  = addr_q;
  assign dev.wdata = wdat_q;
  assign doWr  = awGot_q && wGot_q && !bvalid;
  assign start = doWr && wS_q && awA_q == `ADCPS_AXI_CTRL && wD_q[0];
  assign arA   = araddr;
  // doubled divider code, kept at eight when eight is wanted
  assign dbl = (want_q == `ADCPS_DIV_BY8) ? want_q : want_q + 2'h1;

  // write channel: address and data taken in either order
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      awGot_q <= 1'b0;
      wGot_q  <= 1'b0;
      awA_q   <= 4'h0;
      wD_q    <= 8'h00;
      wS_q    <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `ADCPS_RESP_OKAY;
    end else begin
      awready <= !(awGot_q || (awvalid && awready));
      wready  <= !(wGot_q || (wvalid && wready));
      if (awvalid && awready) begin
        awGot_q <= 1'b1;
        awA_q   <= awaddr;
      end
      if (wvalid && wready) begin
        wGot_q <= 1'b1;
        wD_q   <= wdata[7:0];
        wS_q   <= wstrb[0];
      end
      if (doWr) begin
        awGot_q <= 1'b0;
        wGot_q  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= (awA_q == `ADCPS_AXI_CTRL || awA_q == `ADCPS_AXI_STATUS)
                   ? `ADCPS_RESP_OKAY : `ADCPS_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read channel: one read outstanding, answer one cycle after address
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `ADCPS_RESP_OKAY;
    end else begin
      arready <= !(rvalid || (arvalid && arready));
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= `ADCPS_RESP_OKAY;
        if (arA == `ADCPS_AXI_CTRL) begin
          rdata <= {26'h0, want_q, 4'h0};
        end else if (arA == `ADCPS_AXI_STATUS) begin
          rdata <= {24'h0, st_q, 2'h0, done_q, busy_q};
        end else begin
          rdata <= 32'h0000_0000;
          rresp <= `ADCPS_RESP_SLVERR;
        end
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // sequence; any power-down the software wants goes through this path
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q     <= HST_IDLE;
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
      want_q   <= 2'h0;
      rdPend_q <= 1'b0;
      wrEn_q   <= 1'b0;
      rdEn_q   <= 1'b0;
      addr_q   <= 8'h00;
      wdat_q   <= 8'h00;
    end else begin
      wrEn_q <= 1'b0;
      rdEn_q <= 1'b0;
      unique case (st_q)
        HST_IDLE: if (start) begin
          want_q <= wD_q[5:4];
          busy_q <= 1'b1;
          done_q <= 1'b0;
          st_q   <= HST_POLLP;
        end
        HST_POLLP, HST_POLLC: begin
          if (!rdPend_q) begin
            rdEn_q   <= 1'b1;
            addr_q   <= `ADCPS_REG_LINK;
            rdPend_q <= 1'b1;
          end else if (dev.rdValid) begin
            rdPend_q <= 1'b0;
            if (dev.rdata[`ADCPS_ST_CALDONE]) begin
              st_q <= (st_q == HST_POLLP) ? HST_PD : HST_REST;
            end
          end
        end
        HST_PD: begin
          wrEn_q <= 1'b1;
          addr_q <= `ADCPS_REG_PWR;
          wdat_q <= `ADCPS_PWR_DOWN;
          st_q   <= HST_DIV;
        end
        HST_DIV: begin
          wrEn_q <= 1'b1;
          addr_q <= `ADCPS_REG_DIV;
          wdat_q <= {6'h00, dbl};
          st_q   <= HST_TUNA;
        end
        HST_TUNA: begin
          wrEn_q <= 1'b1;
          addr_q <= `ADCPS_REG_TUNA;
          wdat_q <= `ADCPS_TUNA_VAL;
          st_q   <= HST_TUNB;
        end
        HST_TUNB: begin
          wrEn_q <= 1'b1;
          addr_q <= `ADCPS_REG_TUNB;
          wdat_q <= `ADCPS_TUNB_VAL;
          st_q   <= HST_TUNC;
        end
        HST_TUNC: begin
          wrEn_q <= 1'b1;
          addr_q <= `ADCPS_REG_TUNC;
          wdat_q <= `ADCPS_TUNC_VAL;
          st_q   <= HST_NORM;
        end
        HST_NORM: begin
          wrEn_q <= 1'b1;
          addr_q <= `ADCPS_REG_PWR;
          wdat_q <= `ADCPS_PWR_NORMAL;
          st_q   <= HST_POLLC;
        end
        HST_REST: begin
          wrEn_q <= (want_q != `ADCPS_DIV_BY8);
          addr_q <= `ADCPS_REG_DIV;
          wdat_q <= {6'h00, want_q};
          busy_q <= 1'b0;
          done_q <= 1'b1;
          st_q   <= HST_IDLE;
        end
        default: st_q <= HST_IDLE;
      endcase
    end
  end
endmodule

// >>> rtl/adcps_dev_end.sv
// converter power, calibration and link-configuration sequencer
`timescale 1ns/1ps
`include "adcps_defs.svh"
module adcps_dev_end
  import adcps_pkg::*;
#(
  parameter int unsigned PUP_CYC  = `ADCPS_PUP_CYC,
  parameter int unsigned CALP_CYC = `ADCPS_CALP_CYC,
  parameter int unsigned PDX_CYC  = `ADCPS_PDX_CYC,
  parameter int unsigned CAL_CYC  = `ADCPS_CAL_CYC
)(
  input  wire logic        clock,
  input  wire logic        resetn,
  adcps_if.dev             cfg,
  input  wire logic        supplyOk,
  input  wire logic        clockOk,
  input  wire logic [15:0] sampleIn,
  output logic      [15:0] sampleOut,
  output logic             calDone,
  output logic             linkInit,
  output logic             linkUp,
  output logic             powerDown,
  output logic             sleepMode,
  output logic             twoLanes,
  output logic             scrambleEn,
  output logic             subclassOne,
  output logic             ilaForce,
  output logic      [5:0]  multiframeK,
  output logic      [1:0]  divCode
);
  adcps_dev_state_t st_q;
  logic [1:0]  supSync_q, clkSync_q;
  logic        pinsOk, pdReq, slReq, nrm, tmo, divChg, wrPwrNrm;
  logic        calDone_q, calBusy_q, setCal, clrCal;
  logic [23:0] cnt_q, lim;
  logic [7:0]  pwr_q, div_q, tunA_q, tunB_q, tunC_q, cfg_q, kRaw_q;
  logic [7:0]  kMin, rdMux, rdata_q;
  logic        rdValid_q;
  logic [2:0]  tpIn;
  adcps_test_t tp;
  logic [6:0]  prbs7_q;
  logic [22:0] prbs23_q;
  logic [15:0] ramp_q, fmt;

  // pins are asynchronous to the sampling clock
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      supSync_q <= 2'h0;
      clkSync_q <= 2'h0;
    end else begin
      supSync_q <= {supSync_q[0], supplyOk};
      clkSync_q <= {clkSync_q[0], clockOk};
    end
  end
  assign pinsOk = supSync_q[1] && clkSync_q[1];

  assign pdReq  = (pwr_q == `ADCPS_PWR_DOWN);
  assign slReq  = (pwr_q == `ADCPS_PWR_SLEEP);
  assign nrm    = !pdReq && !slReq;
  assign divChg = cfg.wrEn && cfg.addr == `ADCPS_REG_DIV
                  && cfg.wdata[1:0] != div_q[1:0];
  assign wrPwrNrm = cfg.wrEn && cfg.addr == `ADCPS_REG_PWR
                    && cfg.wdata == `ADCPS_PWR_NORMAL;
  // unsupported pattern codes fall back to normal data
  assign tpIn = (cfg.wdata[6:4] > TP_RAMP) ? TP_NONE : cfg.wdata[6:4];

  // register file: only writes change it, power states never do
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pwr_q  <= `ADCPS_PWR_NORMAL;
      div_q  <= `ADCPS_DIV_RESET;
      tunA_q <= 8'h00;
      tunB_q <= 8'h00;
      tunC_q <= 8'h00;
      cfg_q  <= `ADCPS_CFG_RESET;
      kRaw_q <= `ADCPS_K_RESET;
    end else if (cfg.wrEn) begin
      case (cfg.addr)
        `ADCPS_REG_PWR:  pwr_q  <= cfg.wdata;
        `ADCPS_REG_DIV:  div_q  <= {6'h00, cfg.wdata[1:0]};
        `ADCPS_REG_TUNA: tunA_q <= cfg.wdata;
        `ADCPS_REG_TUNB: tunB_q <= cfg.wdata;
        `ADCPS_REG_TUNC: tunC_q <= cfg.wdata;
        // subclass bit picks 1 or 0 only; no idle or polarity bits exist
        `ADCPS_REG_CFG:  cfg_q  <= {1'b0, tpIn, cfg.wdata[3:0]};
        `ADCPS_REG_KCFG: kRaw_q <= cfg.wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    lim = 24'h000001;
    unique case (st_q)
      DEV_PUP:  lim = 24'(PUP_CYC);
      DEV_CALP: lim = 24'(CALP_CYC);
      DEV_PDX:  lim = 24'(PDX_CYC);
      DEV_CAL:  lim = 24'(CAL_CYC);
      DEV_LINK: lim = 24'(`ADCPS_LINK_CYC);
      default:  lim = 24'h000001;
    endcase
  end
  assign tmo = (cnt_q == lim - 24'h000001);

  // power and calibration sequencing; losing supply or clock restarts it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q  <= DEV_WAIT;
      cnt_q <= 24'h000000;
    end else begin
      cnt_q <= cnt_q + 24'h000001;
      if (!pinsOk) begin
        st_q  <= DEV_WAIT;
        cnt_q <= 24'h000000;
      end else begin
        unique case (st_q)
          DEV_WAIT: begin
            st_q  <= DEV_PUP;
            cnt_q <= 24'h000000;
          end
          DEV_PUP: if (tmo) begin
            st_q  <= DEV_CALP;
            cnt_q <= 24'h000000;
          end
          DEV_CALP: if (tmo) begin
            st_q  <= DEV_LINK;
            cnt_q <= 24'h000000;
          end
          DEV_LINK, DEV_RUN: begin
            if (pdReq) begin
              st_q <= DEV_PD;
            end else if (slReq) begin
              st_q <= DEV_SLEEP;
            end else if (divChg) begin
              st_q  <= DEV_LINK;
              cnt_q <= 24'h000000;
            end else if (st_q == DEV_LINK && tmo) begin
              st_q <= DEV_RUN;
            end
          end
          DEV_PD: if (nrm) begin
            st_q  <= DEV_PDX;
            cnt_q <= 24'h000000;
          end
          DEV_PDX: if (tmo) begin
            st_q  <= DEV_CAL;
            cnt_q <= 24'h000000;
          end
          DEV_CAL: if (tmo) begin
            st_q  <= DEV_LINK;
            cnt_q <= 24'h000000;
          end
          DEV_SLEEP: if (nrm) begin
            st_q  <= DEV_LINK;
            cnt_q <= 24'h000000;
          end
          default: st_q <= DEV_WAIT;
        endcase
      end
    end
  end

  assign setCal = pinsOk && tmo && (st_q == DEV_CALP || st_q == DEV_CAL);
  // cleared on the very write that ends power-down, so a read right
  // behind that write cannot see the flag from the last calibration
  assign clrCal = st_q == DEV_WAIT || (st_q == DEV_PD && (nrm || wrPwrNrm));

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      calDone_q <= 1'b0;
    end else if (setCal) begin
      calDone_q <= 1'b1;
    end else if (clrCal) begin
      calDone_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      calBusy_q <= 1'b0;
      linkInit  <= 1'b0;
      linkUp    <= 1'b0;
      powerDown <= 1'b0;
      sleepMode <= 1'b0;
    end else begin
      calBusy_q <= st_q == DEV_PUP || st_q == DEV_CALP
                   || st_q == DEV_PDX || st_q == DEV_CAL;
      linkInit  <= st_q == DEV_LINK;
      linkUp    <= st_q == DEV_RUN;
      powerDown <= st_q == DEV_PD;
      sleepMode <= st_q == DEV_SLEEP;
    end
  end
  assign calDone = calDone_q;

  always_comb begin
    unique case (cfg.addr)
      `ADCPS_REG_PWR:  rdMux = pwr_q;
      `ADCPS_REG_DIV:  rdMux = div_q;
      `ADCPS_REG_TUNA: rdMux = tunA_q;
      `ADCPS_REG_TUNB: rdMux = tunB_q;
      `ADCPS_REG_TUNC: rdMux = tunC_q;
      `ADCPS_REG_CFG:  rdMux = cfg_q;
      `ADCPS_REG_KCFG: rdMux = kRaw_q;
      `ADCPS_REG_LINK: rdMux = {5'h00, calBusy_q, linkUp, calDone_q};
      default:         rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_q   <= 8'h00;
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= cfg.rdEn;
      if (cfg.rdEn) begin
        rdata_q <= rdMux;
      end
    end
  end
  assign cfg.rdata   = rdata_q;
  assign cfg.rdValid = rdValid_q;

  // multiframe length held inside the range that the lane count allows
  assign kMin = cfg_q[`ADCPS_CFG_TWOLANE] ? `ADCPS_K_MIN2 : `ADCPS_K_MIN1;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      multiframeK <= 6'h00;
      twoLanes    <= 1'b0;
      scrambleEn  <= 1'b0;
      subclassOne <= 1'b0;
      divCode     <= 2'h0;
    end else begin
      multiframeK <= (kRaw_q < kMin) ? kMin[5:0] :
                     (kRaw_q > `ADCPS_K_MAX) ? 6'h20 : kRaw_q[5:0];
      twoLanes    <= cfg_q[`ADCPS_CFG_TWOLANE];
      scrambleEn  <= cfg_q[`ADCPS_CFG_SCRAM];
      subclassOne <= cfg_q[`ADCPS_CFG_SUB1];
      divCode     <= div_q[1:0];
    end
  end

  // sample path: formatting happens ahead of framing and encoding
  assign tp  = adcps_test_t'(cfg_q[6:4]);
  assign fmt = cfg_q[`ADCPS_CFG_OFFBIN] ? {~sampleIn[15], sampleIn[14:0]}
                                        : sampleIn;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prbs7_q   <= 7'h7f;
      prbs23_q  <= 23'h7fffff;
      ramp_q    <= 16'h0000;
      sampleOut <= 16'h0000;
      ilaForce  <= 1'b0;
    end else begin
      prbs7_q  <= {prbs7_q[5:0], prbs7_q[6] ^ prbs7_q[5]};
      prbs23_q <= {prbs23_q[21:0], prbs23_q[22] ^ prbs23_q[17]};
      ramp_q   <= ramp_q + 16'h0001;
      ilaForce <= tp == TP_ILA;
      if (st_q != DEV_RUN && st_q != DEV_LINK) begin
        sampleOut <= 16'h0000;
      end else begin
        unique case (tp)
          TP_D215:   sampleOut <= 16'hb5b5;
          TP_K285:   sampleOut <= 16'hbcbc;
          TP_PRBS7:  sampleOut <= {9'h000, prbs7_q};
          TP_PRBS23: sampleOut <= prbs23_q[15:0];
          TP_RAMP:   sampleOut <= ramp_q;
          default:   sampleOut <= fmt;
        endcase
      end
    end
  end
endmodule

// >>> tb/adcps_props.sv
// assertions on the configuration port and device status outputs
`timescale 1ns/1ps
module adcps_props (
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic       wrEn,
  input wire logic       rdEn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rdValid,
  input wire logic       calDone,
  input wire logic       linkInit,
  input wire logic       linkUp,
  input wire logic       powerDown,
  input wire logic [1:0] divCode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  logic pwrWr;
  assign pwrWr = wrEn && addr == 8'h02;
  read_answer_a: assert property (rdEn |=> rdValid)
    else $error("read not answered");
  status_bit_a: assert property (rdEn && addr == 8'h6c
    |=> rdata[0] == $past(calDone)) else $error("status bit wrong");
  // flag must stay low for eight cycles after the write, then rise with the cal
  exit_delay_a: assert property (pwrWr && wdata == 8'h00 && powerDown
    |=> (!calDone)[*8] ##[18:26] calDone)
    else $error("exit calibration timing");
  // the state flop and then the output flop each add a cycle
  pd_enter_a: assert property (pwrWr && wdata == 8'h01
    |=> ##2 powerDown && !linkUp) else $error("power-down not entered");
  link_start_a: assert property ($rose(calDone)
    |-> ##[0:2] linkInit) else $error("link init missing");
  div_store_a: assert property (wrEn && addr == 8'h13
    |=> ##1 divCode == $past(wdata[1:0], 2))
    else $error("divider not stored");
  // a power-down write just ahead wins over the relink
  div_relink_a: assert property (wrEn && addr == 8'h13
    && wdata[1:0] != divCode && (linkInit || linkUp) && !$past(pwrWr)
    |=> ##1 linkInit && !linkUp) else $error("link not restarted");
  link_ready_a: assert property (linkUp
    |-> calDone && !powerDown) else $error("link up uncalibrated");
endmodule

// >>> tb/test_adc_power_calibration_sequencer.sv
// bench: host and device ends joined, plus a device driven directly
`timescale 1ns/1ps
module test_adc_power_calibration_sequencer;
  logic        clock, resetn, supplyOk, clockOk;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, divCode, divB;
  logic [15:0] sampleIn, smpB;
  logic        calDone, linkInit, linkUp, powerDown;
  logic        calB, lnkB, upB, subB, ilaB, twoB, scrB, slpB;
  logic [5:0]  kB;
  int          n_errors, samples_checked, seed, i;

  adcps_if cfg ();
  adcps_if cfgB ();
  // short counts keep the run brief; expectations use these figures
  adcps_dev_end #(.PUP_CYC(40), .CALP_CYC(20), .PDX_CYC(10), .CAL_CYC(20))
    adcps_dev_end_i (.clock, .resetn, .cfg(cfg), .supplyOk, .clockOk,
    .sampleIn, .sampleOut(), .calDone, .linkInit, .linkUp, .powerDown,
    .sleepMode(), .twoLanes(), .scrambleEn(), .subclassOne(),
    .ilaForce(), .multiframeK(), .divCode);
  adcps_dev_end #(.PUP_CYC(40), .CALP_CYC(20), .PDX_CYC(10), .CAL_CYC(20))
    adcps_dev_end_b_i (.clock, .resetn, .cfg(cfgB), .supplyOk, .clockOk,
    .sampleIn, .sampleOut(smpB), .calDone(calB), .linkInit(lnkB),
    .linkUp(upB), .powerDown(), .sleepMode(slpB), .twoLanes(twoB),
    .scrambleEn(scrB), .subclassOne(subB), .ilaForce(ilaB),
    .multiframeK(kB), .divCode(divB));
  adcps_host_end adcps_host_end_i (.clock, .resetn, .dev(cfg), .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  adcps_props adcps_props_i (.clock, .resetn, .wrEn(cfg.wrEn),
    .rdEn(cfg.rdEn), .addr(cfg.addr), .wdata(cfg.wdata), .rdata(cfg.rdata),
    .rdValid(cfg.rdValid), .calDone, .linkInit, .linkUp, .powerDown,
    .divCode);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      n_errors++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    bit aw = 0, w = 0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clock);
      if (awready && !aw) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (wready && !w) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge clock);
    bready <= 1'b0;
    r = bresp;
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clock);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask

  task automatic cw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    cfgB.wrEn <= 1'b1;
    cfgB.addr <= a;
    cfgB.wdata <= d;
    @(posedge clock);
    cfgB.wrEn <= 1'b0;
  endtask

  task automatic cr(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    cfgB.rdEn <= 1'b1;
    cfgB.addr <= a;
    @(posedge clock);
    cfgB.rdEn <= 1'b0;
    @(posedge clock);
    chk(cfgB.rdValid === 1'b1, "no read answer");
    d = cfgB.rdata;
  endtask

  task automatic waitCal(output int n);
    n = 0;
    while (calB !== 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
  endtask

  initial begin
    logic [7:0] v, u;
    logic [2:0] t;
    logic [1:0] c, r;
    logic [31:0] d;
    int n;
    seed = 32'h7d75;
    {resetn, supplyOk, clockOk, awvalid, wvalid, bready} = '0;
    {arvalid, rready, awaddr, araddr, wdata, sampleIn} = '0;
    {cfgB.wrEn, cfgB.rdEn, cfgB.addr, cfgB.wdata} = '0;
    wstrb = 4'hf;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    supplyOk <= 1'b1;
    clockOk <= 1'b1;
    waitCal(n);
    chk(n >= 60 && n <= 68, "power-up timing");
    cr(8'h6c, v);
    chk(v[0] === 1'b1 && subB === 1'b1, "status");
    for (i = 0; i < 8; i++) begin
      cw(8'h60, {1'b0, i[2:0], 4'h8});
      cr(8'h60, v);
      t = (i < 7) ? i[2:0] : 3'h0;
      chk(v === {1'b0, t, 4'h8} && ilaB === (i == 3), "code");
    end
    cw(8'h60, 8'h0e);
    cw(8'h61, 8'h05);
    repeat (2) @(posedge clock);
    chk(kB === 6'd17 && twoB && scrB, "two-lane K");
    cw(8'h60, 8'h08);
    cw(8'h61, 8'h05);
    repeat (2) @(posedge clock);
    chk(kB === 6'd9 && twoB === 1'b0, "one-lane K");
    cw(8'h61, 8'h28);
    repeat (2) @(posedge clock);
    chk(kB === 6'd32, "K ceiling");
    for (i = 0; i < 2; i++) begin
      cw(8'h60, {7'h04, i[0]});
      sampleIn <= 16'($random(seed));
      repeat (3) @(posedge clock);
      chk(smpB === (sampleIn ^ {i[0], 15'h0}), "format");
    end
    u = 8'($random(seed));
    cw(8'h16, u);
    cw(8'h02, 8'h01);
    cw(8'h02, 8'h00);
    @(posedge clock);
    chk(calB === 1'b0, "flag during exit");
    waitCal(n);
    chk(n >= 28 && n <= 34, "exit delay");
    cw(8'h02, 8'h02);
    repeat (3) @(posedge clock);
    chk(slpB === 1'b1, "sleep entered");
    cw(8'h02, 8'h00);
    repeat (3) @(posedge clock);
    chk(calB === 1'b1 && lnkB === 1'b1, "sleep exit");
    cr(8'h16, v);
    chk(v === u, "tuning kept");
    repeat (20) @(posedge clock);
    chk(upB === 1'b1, "link up");
    cw(8'h13, 8'h02);
    repeat (2) @(posedge clock);
    chk(lnkB === 1'b1 && upB === 1'b0 && divB === 2'h2, "relink");
    // four desired codes in turn, then one drawn at random
    for (i = 0; i < 5; i++) begin
      c = (i < 4) ? i[1:0] : 2'($random(seed));
      axw(4'h0, {26'h0, c, 4'h1}, r);
      chk(r === 2'h0, "ctrl response");
      n = 0;
      do begin
        axr(4'h4, d, r);
        n++;
      end while (d[1:0] !== 2'b10 && n < 100);
      // the restore write lands and reaches divCode two edges later
      repeat (2) @(posedge clock);
      chk(d[1:0] === 2'b10 && divCode === c && calDone, "seq");
    end
    axw(4'h8, 32'h1, r);
    chk(r === 2'h2, "unmapped write");
    axr(4'hc, d, r);
    chk(r === 2'h2, "unmapped read");
    // a lost clock pin sends both devices back to the power-up wait
    clockOk <= 1'b0;
    repeat (5) @(posedge clock);
    chk(calB === 1'b0 && calDone === 1'b0, "pin loss");
    clockOk <= 1'b1;
    waitCal(n);
    chk(n >= 60 && n <= 68, "restart timing");
    // start bit without its byte strobe must not launch a sequence
    wstrb <= 4'h0;
    axw(4'h0, 32'h1, r);
    axr(4'h4, d, r);
    chk(d[1:0] === 2'b10 && r === 2'h0, "masked start");
    resetn <= 1'b0;
    supplyOk <= 1'b0;
    repeat (2) @(posedge clock);
    chk(calDone === 1'b0 && awready === 1'b0, "reset held");
    resetn <= 1'b1;
    supplyOk <= 1'b1;
    waitCal(n);
    chk(n >= 60 && n <= 68, "second power-up");
    axr(4'h4, d, r);
    chk(d === 32'h0 && r === 2'h0, "host after reset");
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    print_verdict();
  end
endmodule
